// ==== bench/iavc_codec_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module iavc_codec_model (
	output logic o_av_clock,
	output logic o_first_byte,
	output logic o_key
);
	////////////////////////////////////////////////////////////////////////////////
	// byte clock runs free, so a receiver reset always sees whole periods
	initial begin
		o_av_clock = 1'b0;
		o_first_byte = 1'b0;
		o_key = 1'b0;
		#3;
		forever #80 o_av_clock = ~o_av_clock;
	end

	////////////////////////////////////////////////////////////////////////////////
	// one packet, a single key per packet; the key flips after the first byte
	// so a sample taken at the wrong byte shows up
	task send(input logic k);
		@(negedge o_av_clock);
		o_key = k;
		o_first_byte = 1'b1;
		@(negedge o_av_clock);
		o_first_byte = 1'b0;
		o_key = ~k;
		repeat (6) @(negedge o_av_clock);
	endtask
endmodule
`default_nettype wire

// ==== bench/iavc_ctrl_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module iavc_ctrl_checker #(
	parameter int FIFO_QUADS = 1024
) (
	input wire logic                  I_MCLK,
	input wire logic                  I_RESET_N,
	input wire logic [7:0]            I_ADDR,
	input wire logic [31:0]           I_WDATA,
	input wire logic                  I_WR,
	input wire logic                  I_RD,
	input wire logic [31:0]           O_RDATA,
	input wire logic [1:0]            O_TX_TAG,
	input wire logic [5:0]            O_TX_CHANNEL,
	input wire logic [1:0]            O_TX_SPEED,
	input wire logic [3:0]            O_TX_SYNC,
	input wire iavc_pkg::iavc_rxpkt_t I_RX_PKT,
	input wire logic                  I_RX_OUT_ACTIVE,
	input wire logic                  I_RX_OUT_START,
	input wire logic                  O_RX_STAMP_OUT,
	input wire logic                  O_RX_STAMP_PROC,
	input wire logic [1:0]            O_RX_PAD_STRIP,
	input wire logic                  O_RX_RESET,
	input wire logic                  O_PORT_KEY_PIN_O,
	input wire logic                  O_PORT_KEY_PIN_OE
);
	// single clock domain, so clocking and reset are shared
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RESET_N);

	// writes to the two control words
	wire logic txw = I_WR && (I_ADDR == 8'h34);
	wire logic rxw = I_WR && (I_ADDR == 8'h40);

	////////////////////////////////////////////////////////////////////////////////
	AST_TX_TAG: assert property (txw |=> O_TX_TAG == $past(I_WDATA[15:14]))
		else $error("tag not loaded");
	AST_TX_CHANNEL: assert property (txw |-> ##1 O_TX_CHANNEL == $past(I_WDATA[13:8]))
		else $error("channel not loaded");
	AST_TX_SPEED: assert property ($changed(O_TX_SPEED) |-> $past(txw))
		else $error("speed moved without a write");
	AST_TX_SYNC: assert property (O_TX_SYNC[3:2] == 2'h0 && !O_TX_SYNC[0])
		else $error("sync bits other than key set");
	AST_TXMEM_RD: assert property (I_RD && I_ADDR == 8'h38 |=> O_RDATA[31:7] == 25'h0)
		else $error("memory status upper bits set");
	AST_KEY_OE: assert property (O_PORT_KEY_PIN_OE == I_RX_OUT_ACTIVE)
		else $error("key pin enable wrong");
	AST_KEY_LATCH: assert property (I_RX_OUT_START |=> O_PORT_KEY_PIN_O == $past(I_RX_PKT.key))
		else $error("key not latched at output start");
	AST_KEY_HOLD: assert property ($past(I_RX_OUT_ACTIVE) && !$past(I_RX_OUT_START)
		&& I_RX_OUT_ACTIVE |-> $stable(O_PORT_KEY_PIN_O))
		else $error("key moved inside a packet");
	AST_RX_PAD: assert property (rxw |=> O_RX_PAD_STRIP == $past(I_WDATA[3:2]))
		else $error("pad strip not loaded");
	AST_RX_STAMP_OUT: assert property (rxw ##1 1'b1 |-> O_RX_STAMP_OUT == $past(I_WDATA[7]))
		else $error("stamp output not loaded");
	AST_RX_STAMP_PROC: assert property (rxw |=> O_RX_STAMP_PROC == $past(I_WDATA[1]))
		else $error("stamp processing not loaded");
	AST_RX_RESET: assert property (rxw && !I_WDATA[0] |=> !O_RX_RESET)
		else $error("receiver reset not released");
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic                  clk = 1'b0;
	logic                  rst_n = 1'b0;
	logic                  wr = 1'b0;
	logic                  rd = 1'b0;
	logic [7:0]            addr = 8'h00;
	logic [31:0]           wd = 32'h0;
	logic [10:0]           txl = 11'h0;
	logic [10:0]           rxl = 11'h0;
	iavc_pkg::iavc_rxpkt_t pk = '0;
	logic                  oact = 1'b0;
	logic                  ostart = 1'b0;
	logic                  sdue = 1'b0;
	logic                  sready = 1'b0;
	logic                  lk = 1'b0;
	logic [3:0]            ev = 4'h0;
	logic [31:0]           rdata, r, w, h1, h2;
	logic [1:0]            tag, spd, pad;
	logic [5:0]            ch;
	logic [3:0]            sync;
	iavc_pkg::iavc_dlv_t   dlv, d;
	logic                  av_port_clock, first, key, acc, sout, sproc, rrst, ko, koe, co, coe, irq;
	int                    err_total = 0, num_checks = 0, n, k, seed = 32'h6BA8B37A;
	logic [7:0]            ra [6] = '{8'h34, 8'h38, 8'h40, 8'h44, 8'h48, 8'h4C};
	logic [31:0]           rv [6] = '{32'h0, 32'h3, 32'h41, 32'h0, 32'hFFFF, 32'h0};
	int                    lv [10] = '{0, 1, 511, 512, 768, 924, 1019, 1020, 1023, 1024};
	int                    pos [4] = '{5, 4, 0, 1};

	always #5 clk = ~clk;

	iavc_ctrl iavc_ctrl_inst (
		.I_MCLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr), .I_WDATA(wd), .I_WR(wr), .I_RD(rd),
		.O_RDATA(rdata), .I_AV_PORT_CLOCK(av_port_clock), .I_TX_FIRST_BYTE(first), .I_PORT_KEY_PIN(key),
		.I_TX_FIFO_LEVEL(txl), .O_TX_TAG(tag), .O_TX_CHANNEL(ch), .O_TX_SPEED(spd),
		.O_TX_SYNC(sync), .I_RX_PKT(pk), .I_RX_OUT_ACTIVE(oact), .I_RX_OUT_START(ostart),
		.I_RX_STAMP_DUE(sdue), .I_RX_SRC_READY(sready), .I_RX_FIFO_LEVEL(rxl),
		.I_RX_FSYNC(ev[0]), .I_RX_SEQ_ERR(ev[1]), .I_RX_STATUS_QUEUE_OVERFLOW(ev[2]), .I_RX_DONE(ev[3]),
		.O_RX_DELIVER(dlv), .O_RX_ACCEPT(acc), .O_RX_STAMP_OUT(sout), .O_RX_STAMP_PROC(sproc),
		.O_RX_PAD_STRIP(pad), .O_RX_RESET(rrst), .O_PORT_KEY_PIN_O(ko),
		.O_PORT_KEY_PIN_OE(koe), .O_AV_CLK_O(co), .O_AV_CLK_OE(coe), .O_RX_IRQ(irq)
	);

	iavc_codec_model iavc_codec_model_inst (.o_av_clock(av_port_clock), .o_first_byte(first), .o_key(key));

	////////////////////////////////////////////////////////////////////////////////
	// expected memory status for a given fill level of a 1024-quadlet store
	function automatic logic [31:0] exp_tx(input int l);
		return {25'h0, l >= 924, l >= 768, l >= 512, l == 1024, l == 1023, l <= 1019, l == 0};
	endfunction

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task conclude;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task cyc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask

	// bus cycles: one strobe cycle each, read data taken in the cycle after
	task wrt(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wd <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 r = rdata;
		chk(r & m, e);
	endtask

	// one received packet; headers stay on the port after the start pulse
	task pkt(input logic [31:0] a, input logic [31:0] b, input logic c);
		@(posedge clk);
		pk <= {1'b1, c, lk, 1'b1, a, b};
		#1 d = dlv;
		@(posedge clk);
		pk.start <= 1'b0;
		#1;
	endtask

	// high time of the generated port clock, bounded so a dead clock cannot hang
	task avper;
		n = 0;
		for (k = 0; k < 40 && co !== 1'b0; k++) @(posedge clk) #1;
		for (k = 0; k < 40 && co !== 1'b1; k++) @(posedge clk) #1;
		if (k == 40) begin
			err_total++;
			conclude;
		end
		for (k = 0; k < 40 && co === 1'b1; k++) @(posedge clk) #1 n++;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		foreach (ra[i]) rdc(ra[i], 32'hFFFFFFFF, rv[i]);
		rdc(8'h60, 32'hFFFFFFFF, 32'h0);
		$display("end of reset values");
		// random header fields, every speed code among them
		for (int i = 0; i < 8; i++) begin
			w = $random(seed);
			w[5:4] = i[1:0];
			wrt(8'h34, w);
			cyc(1);
			chk({22'h0, tag, ch, spd}, {22'h0, w[15:8], w[5:4]});
			rdc(8'h34, 32'hFFFFFF3F, (w & 32'hFF30) | {30'h0, lk, 1'b0});
		end
		// key taken only with the first byte of each packet
		for (int i = 1; i >= 0; i--) begin
			lk = i[0];
			iavc_codec_model_inst.send(lk);
			cyc(8);
			chk({28'h0, sync}, {30'h0, lk, 1'b0});
		end
		$display("end of transmit header");
		wrt(8'h38, 32'hFFFFFFFF);
		foreach (lv[i]) begin
			@(posedge clk) txl <= lv[i][10:0];
			cyc(3);
			rdc(8'h38, 32'hFFFFFFFF, exp_tx(lv[i]));
		end
		$display("end of memory status");
		// receiver reset has stood since power-up for far longer than a byte clock
		for (int i = 0; i < 6; i++) begin
			w = $random(seed);
			w[0] = 1'b0;
			wrt(8'h40, w);
			rdc(8'h40, 32'hFFFFFFFF, w & 32'h300001DF);
		end
		for (int i = 1; i < 4; i++) begin
			wrt(8'h40, {2'b00, i[1:0], 28'h10});
			cyc(2);
			chk({31'h0, coe}, 32'h1);
			avper;
			chk(n, 2 << (i - 1));
		end
		wrt(8'h40, 32'h10);
		cyc(1);
		chk({31'h0, coe}, 32'h0);
		@(posedge clk) sready <= 1'b1;
		cyc(3);
		rdc(8'h40, 32'h20, 32'h20);
		@(posedge clk) sready <= 1'b0;
		$display("end of receive control");
		w = $random(seed);
		h1 = {2'b00, w[29:0]};
		w = $random(seed);
		h2 = {2'b10, w[29:0]};
		pkt(h1, h2, 1'b1);
		chk({31'h0, acc}, 32'h1);
		chk(dlv, iavc_pkg::IAVC_DLV_WAIT);
		rdc(8'h44, 32'hFFFFFFFF, h1);
		rdc(8'h48, 32'hFFFFFFFF, h2);
		wrt(8'h40, 32'h110);
		cyc(1);
		chk(dlv, iavc_pkg::IAVC_DLV_SEND);
		wrt(8'h40, 32'h150);
		cyc(1);
		chk(dlv, iavc_pkg::IAVC_DLV_DROP);
		wrt(8'h40, 32'h0);
		cyc(2);
		chk({31'h0, acc}, 32'h1);
		// crc-error packet without send-now leaves only when its stamp is due
		@(posedge clk) sdue <= 1'b1;
		cyc(1);
		chk(dlv, iavc_pkg::IAVC_DLV_SEND);
		@(posedge clk) sdue <= 1'b0;
		pkt(h2, h1, 1'b0);
		chk({31'h0, acc}, 32'h0);
		rdc(8'h44, 32'hFFFFFFFF, h1);
		// faulty header end bits while enabled
		wrt(8'h40, 32'h10);
		wrt(8'h50, 32'h4);
		pkt(h1, h2, 1'b0); // good packet first, so only the header can force a drop
		pkt({2'b01, h1[29:0]}, h2, 1'b0);
		chk(d, iavc_pkg::IAVC_DLV_DROP);
		rdc(8'h44, 32'hFFFFFFFF, h1);
		rdc(8'h4C, 32'h4, 32'h4);
		chk({31'h0, irq}, 32'h1);
		wrt(8'h50, 32'h0);
		cyc(1);
		chk({31'h0, irq}, 32'h0);
		wrt(8'h4C, 32'h4);
		rdc(8'h4C, 32'h4, 32'h0);
		$display("end of receive packets");
		foreach (pos[i]) begin
			@(posedge clk) ev <= 4'h1 << i;
			@(posedge clk) ev <= 4'h0;
			rdc(8'h4C, 32'h1 << pos[i], 32'h1 << pos[i]);
			wrt(8'h4C, 32'h1 << pos[i]);
			rdc(8'h4C, 32'h1 << pos[i], 32'h0);
		end
		@(posedge clk) rxl <= 11'h400;
		cyc(2);
		rdc(8'h4C, 32'h780, 32'h780);
		@(posedge clk) rxl <= 11'h0;
		cyc(2);
		rdc(8'h4C, 32'h40, 32'h40);
		$display("end of receive flags");
		@(posedge clk) oact <= 1'b1;
		ostart <= 1'b1;
		pk.key <= 1'b1;
		@(posedge clk) ostart <= 1'b0;
		pk.key <= 1'b0;
		cyc(5);
		chk({30'h0, koe, ko}, 32'h3);
		@(posedge clk) oact <= 1'b0;
		// disable, store already drained, then reset held over a byte clock
		wrt(8'h40, 32'h0);
		wrt(8'h40, 32'h1);
		cyc(20);
		chk({31'h0, rrst}, 32'h1);
		wrt(8'h40, 32'h0);
		rdc(8'h44, 32'hFFFFFFFF, 32'h0);
		rdc(8'h48, 32'hFFFFFFFF, 32'hFFFF);
		$display("end of receiver reset");
		conclude;
	end
endmodule

bind iavc_ctrl iavc_ctrl_checker #(.FIFO_QUADS(FIFO_QUADS)) iavc_ctrl_checker_inst (
	.I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
	.I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_TX_TAG(O_TX_TAG),
	.O_TX_CHANNEL(O_TX_CHANNEL), .O_TX_SPEED(O_TX_SPEED), .O_TX_SYNC(O_TX_SYNC),
	.I_RX_PKT(I_RX_PKT), .I_RX_OUT_ACTIVE(I_RX_OUT_ACTIVE), .I_RX_OUT_START(I_RX_OUT_START),
	.O_RX_STAMP_OUT(O_RX_STAMP_OUT), .O_RX_STAMP_PROC(O_RX_STAMP_PROC),
	.O_RX_PAD_STRIP(O_RX_PAD_STRIP), .O_RX_RESET(O_RX_RESET),
	.O_PORT_KEY_PIN_O(O_PORT_KEY_PIN_O), .O_PORT_KEY_PIN_OE(O_PORT_KEY_PIN_OE)
);
`default_nettype wire

// ==== core/iavc_ctrl.sv ====
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "iavc_defines.svh"

// Notes on behaviour
// (R1) tag from tx control bits 15..14 goes into every outgoing header
// (R2) outgoing packets use the six-bit channel from bits 13..8
// (R3) speed code from bits 5..4; 11 reserved
// (R4) sync bits 3..0 read-only; bit 1 is the key from the pin
// (R5) key pin sampled on av clock rise with first byte, held per packet
// (R6) application never keeps two key changes in the fifo at once
// (R7) receive key pin driven for all bytes of the output packet
// (R8) tx memory status read-only level flags, resets to 0x03
// (R9) software disables and drains before resetting the receiver
// (R10) clock select 00 input; 01/10/11 drive 24.576/12.288/6.144 MHz; code drives the clock only while rx_enable is also set
// (R11) send-now bit releases crc-error packets at once, else wait stamp
// (R12) stamp check disable outputs the stamp quadlet ahead of the packet
// (R13) drop-unreliable bit removes bad packets instead of delivering
// (R14) bit 5 reports a complete source packet is ready
// (R15) receiver enable sampled only when a new packet arrives
// (R16) strip 0..3 pad bytes from last data quadlet per bits 3..2
// (R17) bit 0 resets receiver synchronously; held one av clock period
// (R18) first cip header quadlet captured read-only
// (R19) second cip header quadlet captured read-only, resets 0x0000FFFF
// (R20) stamp enable treats low 16 bits of second quadlet as stamp
// (R21) receive interrupt flags for levels and events
// (R22) wrong end/format bits drop packet and raise tag fault
// (R23) software resets receiver after full or overflow
// (R24) one interrupt enable per receive flag, bits 10..0
// (R25) flags stay set until acknowledged by software
module iavc_ctrl #(
	parameter int FIFO_QUADS = 1024
) (
	input  wire logic                I_MCLK,
	input  wire logic                I_RESET_N,
	input  wire logic [7:0]          I_ADDR,
	input  wire logic [31:0]         I_WDATA,
	input  wire logic                I_WR,
	input  wire logic                I_RD,
	output logic      [31:0]         O_RDATA,
	input  wire logic                I_AV_PORT_CLOCK,
	input  wire logic                I_TX_FIRST_BYTE,
	input  wire logic                I_PORT_KEY_PIN,
	input  wire logic [10:0]         I_TX_FIFO_LEVEL,
	output logic      [1:0]          O_TX_TAG,
	output logic      [5:0]          O_TX_CHANNEL,
	output logic      [1:0]          O_TX_SPEED,
	output logic      [3:0]          O_TX_SYNC,
	input  wire iavc_pkg::iavc_rxpkt_t I_RX_PKT,
	input  wire logic                I_RX_OUT_ACTIVE,
	input  wire logic                I_RX_OUT_START,
	input  wire logic                I_RX_STAMP_DUE,
	input  wire logic                I_RX_SRC_READY,
	input  wire logic [10:0]         I_RX_FIFO_LEVEL,
	input  wire logic                I_RX_FSYNC,
	input  wire logic                I_RX_SEQ_ERR,
	input  wire logic                I_RX_STATUS_QUEUE_OVERFLOW,
	input  wire logic                I_RX_DONE,
	output iavc_pkg::iavc_dlv_t      O_RX_DELIVER,
	output logic                     O_RX_ACCEPT,
	output logic                     O_RX_STAMP_OUT,
	output logic                     O_RX_STAMP_PROC,
	output logic      [1:0]          O_RX_PAD_STRIP,
	output logic                     O_RX_RESET,
	output logic                     O_PORT_KEY_PIN_O,
	output logic                     O_PORT_KEY_PIN_OE,
	output logic                     O_AV_CLK_O,
	output logic                     O_AV_CLK_OE,
	output logic                     O_RX_IRQ
);

	////////////////////////////////////////////////////////////////////////
	// registers

	iavc_pkg::iavc_txctl_t txctl_q;
	iavc_pkg::iavc_rxctl_t rxctl_q;
	logic [31:0]           hq1_q;
	logic [31:0]           hq2_q;
	logic [10:0]           irq_q;
	logic [10:0]           irq_set;
	logic [10:0]           inte_q;
	logic [6:0]            txmem_q;
	logic [31:0]           rdata_d;
	logic                  wr_txctl;
	logic                  wr_rxctl;
	logic                  wr_ack;
	logic                  wr_inte;

	assign wr_txctl = I_WR && (I_ADDR == `IAVC_OFF_TXCTL);
	assign wr_rxctl = I_WR && (I_ADDR == `IAVC_OFF_RXCTL);
	assign wr_ack   = I_WR && (I_ADDR == `IAVC_OFF_RXACK);
	assign wr_inte  = I_WR && (I_ADDR == `IAVC_OFF_RXINTE);

	////////////////////////////////////////////////////////////////////////
	// av clock synchroniser and edge detect

	logic av_port_clock_s1_q;
	logic av_port_clock_s2_q;
	logic av_port_clock_s3_q;
	logic av_rise;
	logic first_s1_q;
	logic first_s2_q;
	logic key_s1_q;
	logic key_s2_q;

	// two-stage sync; third stage only for edge detection
	always_ff @(posedge I_MCLK) begin
		if (!I_RESET_N) begin
			av_port_clock_s1_q <= 1'b0;
			av_port_clock_s2_q <= 1'b0;
			av_port_clock_s3_q <= 1'b0;
			first_s1_q <= 1'b0;
			first_s2_q <= 1'b0;
			key_s1_q   <= 1'b0;
			key_s2_q   <= 1'b0;
		end else begin
			av_port_clock_s1_q <= I_AV_PORT_CLOCK;
			av_port_clock_s2_q <= av_port_clock_s1_q;
			av_port_clock_s3_q <= av_port_clock_s2_q;
			first_s1_q <= I_TX_FIRST_BYTE;
			first_s2_q <= first_s1_q;
			key_s1_q   <= I_PORT_KEY_PIN;
			key_s2_q   <= key_s1_q;
		end
	end

	assign av_rise = av_port_clock_s2_q && !av_port_clock_s3_q;

	////////////////////////////////////////////////////////////////////////
	// transmit header control

	logic tx_key_q;
	// key latched once per packet; pin ignored mid-packet
	always_ff @(posedge I_MCLK) begin
		if (!I_RESET_N) begin
			tx_key_q <= 1'b0;
		end else if (av_rise && first_s2_q) begin
			tx_key_q <= key_s2_q; // (R5)
		end
	end

	// only tag, channel and speed are writable
	always_ff @(posedge I_MCLK) begin
		if (!I_RESET_N) begin
			txctl_q <= `IAVC_RST_TXCTL;
		end else if (wr_txctl) begin
			txctl_q.tag     <= I_WDATA[15:14];
			txctl_q.channel <= I_WDATA[13:8];
			txctl_q.speed   <= I_WDATA[5:4];
		end
	end

	assign O_TX_TAG     = txctl_q.tag; // (R1)
	assign O_TX_CHANNEL = txctl_q.channel; // (R2)
	assign O_TX_SPEED   = txctl_q.speed; // (R3)
	assign O_TX_SYNC    = {2'b00, tx_key_q, 1'b0}; // (R4)

	////////////////////////////////////////////////////////////////////////
	// transmit memory status flags

	logic [10:0] tx_free;

	assign tx_free = 11'(FIFO_QUADS) - I_TX_FIFO_LEVEL;

	// registered so reads see a stable snapshot
	always_ff @(posedge I_MCLK) begin
		if (!I_RESET_N) begin
			txmem_q <= `IAVC_RST_TXMEM; // (R8)
		end else begin
			txmem_q[6] <= I_TX_FIFO_LEVEL >= `IAVC_LVL_100;
			txmem_q[5] <= I_TX_FIFO_LEVEL >= `IAVC_LVL_256;
			txmem_q[4] <= I_TX_FIFO_LEVEL >= `IAVC_LVL_HALF;
			txmem_q[3] <= tx_free == 11'd0;
			txmem_q[2] <= tx_free == 11'd1;
			txmem_q[1] <= tx_free >= `IAVC_FREE_FIVE;
			txmem_q[0] <= I_TX_FIFO_LEVEL == 11'd0; // (R8)
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive unpack control

	// bit 5 is status, not stored from writes
	always_ff @(posedge I_MCLK) begin
		if (!I_RESET_N) begin
			rxctl_q <= `IAVC_RST_RXCTL;
		end else begin
			if (wr_rxctl) begin
				rxctl_q.rx_app_clock_select     <= I_WDATA[29:28];
				rxctl_q.send_now_on_crc_error   <= I_WDATA[8];
				rxctl_q.stamp_check_disable     <= I_WDATA[7];
				rxctl_q.drop_unreliable_packets <= I_WDATA[6];
				rxctl_q.rx_enable               <= I_WDATA[4];
				rxctl_q.byte_pad_strip          <= I_WDATA[3:2];
				rxctl_q.stamp_processing_enable <= I_WDATA[1];
				rxctl_q.rx_reset                <= I_WDATA[0];
			end
			rxctl_q.source_packet_ready <= I_RX_SRC_READY; // (R14)
		end
	end

	// receiver state clears only once the reset has spanned an av clock rise;
	// with no av clock supplied the captured headers and accept flag are never cleared
	logic rx_rst_seen_q;
	always_ff @(posedge I_MCLK) begin
		if (!I_RESET_N) begin
			rx_rst_seen_q <= 1'b0;
		end else if (!rxctl_q.rx_reset) begin
			rx_rst_seen_q <= 1'b0;
		end else if (av_rise) begin
			rx_rst_seen_q <= 1'b1; // (R17)
		end
	end

	assign O_RX_RESET = rxctl_q.rx_reset; // (R17)

	// enable only looked at when a packet starts, so transfers finish
	logic rx_active_q;
	always_ff @(posedge I_MCLK) begin
		if (!I_RESET_N || rx_rst_seen_q) begin
			rx_active_q <= 1'b0;
		end else if (I_RX_PKT.start) begin
			rx_active_q <= rxctl_q.rx_enable; // (R15)
		end
	end

	assign O_RX_ACCEPT = rx_active_q;

	// header check on arrival
	logic hdr_bad;

	assign hdr_bad = (I_RX_PKT.hq1[31:30] != `IAVC_EF_FIRST)
		|| (I_RX_PKT.hq2[31:30] != `IAVC_EF_SECOND); // (R22)

	// capture headers of accepted, well-formed packets
	always_ff @(posedge I_MCLK) begin
		if (!I_RESET_N || rx_rst_seen_q) begin
			hq1_q <= `IAVC_RST_RXHQ1; // (R17)
			hq2_q <= `IAVC_RST_RXHQ2;
		end else if (I_RX_PKT.start && rxctl_q.rx_enable && !hdr_bad) begin
			hq1_q <= I_RX_PKT.hq1; // (R18)
			hq2_q <= I_RX_PKT.hq2; // (R19)
		end
	end

	////////////////////////////////////////////////////////////////////////
	// delivery decision

	// bad packets: drop, rush or wait for the stamp
	always_comb begin
		if (!rx_active_q || (I_RX_PKT.start && hdr_bad)) begin
			O_RX_DELIVER = iavc_pkg::IAVC_DLV_DROP; // (R22)
		end else if (I_RX_PKT.crc_error && rxctl_q.drop_unreliable_packets) begin
			O_RX_DELIVER = iavc_pkg::IAVC_DLV_DROP; // (R13)
		end else if (I_RX_PKT.crc_error && rxctl_q.send_now_on_crc_error) begin
			O_RX_DELIVER = iavc_pkg::IAVC_DLV_SEND; // (R11)
		end else if (I_RX_STAMP_DUE) begin
			O_RX_DELIVER = iavc_pkg::IAVC_DLV_SEND; // (R11)
		end else begin
			O_RX_DELIVER = iavc_pkg::IAVC_DLV_WAIT;
		end
	end

	assign O_RX_STAMP_OUT  = rxctl_q.stamp_check_disable; // (R12)
	assign O_RX_STAMP_PROC = rxctl_q.stamp_processing_enable; // (R20)
	assign O_RX_PAD_STRIP  = rxctl_q.byte_pad_strip; // (R16)

	////////////////////////////////////////////////////////////////////////
	// receive key output

	logic rx_key_q;
	// key latched at output start, held for every byte
	always_ff @(posedge I_MCLK) begin
		if (!I_RESET_N) begin
			rx_key_q <= 1'b0;
		end else if (I_RX_OUT_START) begin
			rx_key_q <= I_RX_PKT.key; // (R7)
		end
	end

	assign O_PORT_KEY_PIN_O  = rx_key_q;
	assign O_PORT_KEY_PIN_OE = I_RX_OUT_ACTIVE; // (R7)

	////////////////////////////////////////////////////////////////////////
	// receive application clock divider

	logic [3:0] div_cnt_q;
	logic [3:0] div_half;
	logic       av_port_clock_out_q;

	always_comb begin
		case (rxctl_q.rx_app_clock_select)
			2'b01:   div_half = `IAVC_HALF_24M;
			2'b10:   div_half = `IAVC_HALF_12M;
			2'b11:   div_half = `IAVC_HALF_6M;
			default: div_half = `IAVC_HALF_24M;
		endcase
	end

	// 100 MHz cannot hit 24.576 exactly; nearest even divide used
	always_ff @(posedge I_MCLK) begin
		if (!I_RESET_N || rxctl_q.rx_app_clock_select == 2'b00) begin
			div_cnt_q   <= 4'h0;
			av_port_clock_out_q <= 1'b0;
		end else if (div_cnt_q >= div_half - 4'h1) begin
			div_cnt_q   <= 4'h0;
			av_port_clock_out_q <= !av_port_clock_out_q; // (R10)
		end else begin
			div_cnt_q <= div_cnt_q + 4'h1;
		end
	end

	assign O_AV_CLK_O  = av_port_clock_out_q;
	assign O_AV_CLK_OE = (rxctl_q.rx_app_clock_select != 2'b00) && rxctl_q.rx_enable; // (R10)

	////////////////////////////////////////////////////////////////////////
	// receive interrupt flags

	logic [10:0] lvl_q;
	always_ff @(posedge I_MCLK) begin
		if (!I_RESET_N) begin
			lvl_q <= 11'h000;
		end else begin
			lvl_q <= I_RX_FIFO_LEVEL;
		end
	end

	// level flags fire on the crossing, not while above
	always_comb begin
		irq_set = 11'h000;
		irq_set[10] = I_RX_FIFO_LEVEL >= `IAVC_LVL_100 && lvl_q < `IAVC_LVL_100;
		irq_set[9]  = I_RX_FIFO_LEVEL >= `IAVC_LVL_256 && lvl_q < `IAVC_LVL_256;
		irq_set[8]  = I_RX_FIFO_LEVEL >= `IAVC_LVL_HALF && lvl_q < `IAVC_LVL_HALF;
		irq_set[`IAVC_IRQ_FULL]  = I_RX_FIFO_LEVEL == 11'(FIFO_QUADS)
			&& lvl_q != 11'(FIFO_QUADS);
		irq_set[`IAVC_IRQ_EMPTY] = I_RX_FIFO_LEVEL == 11'd0 && lvl_q != 11'd0;
		irq_set[`IAVC_IRQ_FSYNC] = I_RX_FSYNC;
		irq_set[`IAVC_IRQ_SEQ]   = I_RX_SEQ_ERR;
		irq_set[`IAVC_IRQ_CRC]   = I_RX_PKT.start && rx_active_q && I_RX_PKT.crc_error;
		irq_set[`IAVC_IRQ_TAG]   = I_RX_PKT.start && rxctl_q.rx_enable && hdr_bad; // (R22)
		irq_set[`IAVC_IRQ_DONE]  = I_RX_DONE;
		irq_set[`IAVC_IRQ_STATUS_QUEUE_OVERFLOW]  = I_RX_STATUS_QUEUE_OVERFLOW; // (R21)
	end

	// write one to acknowledge; a new event beats the clear
	genvar gi;
	generate
		for (gi = 0; gi < `IAVC_IRQ_WIDTH; gi++) begin : g_irq
			always_ff @(posedge I_MCLK) begin
				if (!I_RESET_N) begin
					irq_q[gi] <= 1'b0;
				end else if (irq_set[gi]) begin
					irq_q[gi] <= 1'b1; // (R21)
				end else if (wr_ack && I_WDATA[gi]) begin
					irq_q[gi] <= 1'b0; // (R25)
				end
			end
		end
	endgenerate

	always_ff @(posedge I_MCLK) begin
		if (!I_RESET_N) begin
			inte_q <= 11'h000;
		end else if (wr_inte) begin
			inte_q <= I_WDATA[10:0]; // (R24)
		end
	end

	assign O_RX_IRQ = |(irq_q & inte_q); // (R24)

	////////////////////////////////////////////////////////////////////////
	// register read port

	always_comb begin
		case (I_ADDR)
			`IAVC_OFF_TXCTL:  rdata_d = {txctl_q[31:4], O_TX_SYNC};
			`IAVC_OFF_TXMEM:  rdata_d = {25'h0, txmem_q};
			`IAVC_OFF_RXCTL:  rdata_d = rxctl_q;
			`IAVC_OFF_RXHQ1:  rdata_d = hq1_q;
			`IAVC_OFF_RXHQ2:  rdata_d = hq2_q;
			`IAVC_OFF_RXACK:  rdata_d = {21'h0, irq_q};
			`IAVC_OFF_RXINTE: rdata_d = {21'h0, inte_q};
			default:          rdata_d = 32'h0000_0000;
		endcase
	end

	// read data valid exactly one cycle after the strobe
	always_ff @(posedge I_MCLK) begin
		if (!I_RESET_N) begin
			O_RDATA <= 32'h0000_0000;
		end else if (I_RD) begin
			O_RDATA <= rdata_d;
		end else begin
			O_RDATA <= 32'h0000_0000;
		end
	end

endmodule

`default_nettype wire

// ==== core/iavc_defines.svh ====
`ifndef IAVC_DEFINES_SVH
`define IAVC_DEFINES_SVH

// register offsets (byte addresses)
`define IAVC_OFF_TXCTL   8'h34
`define IAVC_OFF_TXMEM   8'h38
`define IAVC_OFF_RXCTL   8'h40
`define IAVC_OFF_RXHQ1   8'h44
`define IAVC_OFF_RXHQ2   8'h48
`define IAVC_OFF_RXACK   8'h4C
`define IAVC_OFF_RXINTE  8'h50

// reset values
`define IAVC_RST_TXCTL   32'h0000_0000
`define IAVC_RST_TXMEM   7'h03
`define IAVC_RST_RXCTL   32'h0000_0041
`define IAVC_RST_RXHQ1   32'h0000_0000
`define IAVC_RST_RXHQ2   32'h0000_FFFF

// fifo level thresholds in quadlets
`define IAVC_LVL_100     11'd924
`define IAVC_LVL_256     11'd768
`define IAVC_LVL_HALF    11'd512
`define IAVC_FREE_FIVE   11'd5

// cip header end/format codes
`define IAVC_EF_FIRST    2'h0
`define IAVC_EF_SECOND   2'h2

// interrupt flag bit positions
`define IAVC_IRQ_WIDTH   11
`define IAVC_IRQ_FULL    7
`define IAVC_IRQ_EMPTY   6
`define IAVC_IRQ_FSYNC   5
`define IAVC_IRQ_SEQ     4
`define IAVC_IRQ_CRC     3
`define IAVC_IRQ_TAG     2
`define IAVC_IRQ_DONE    1
`define IAVC_IRQ_STATUS_QUEUE_OVERFLOW    0

// clock divider half periods at 100 MHz (nearest integer counts)
`define IAVC_HALF_24M    4'd2
`define IAVC_HALF_12M    4'd4
`define IAVC_HALF_6M     4'd8

`endif

// ==== core/iavc_pkg.sv ====
`default_nettype none
package iavc_pkg;

	// transmit header control layout
	typedef struct packed {
		logic [15:0] unused_hi;
		logic [1:0]  tag;
		logic [5:0]  channel;
		logic [1:0]  unused_lo;
		logic [1:0]  speed;
		logic [3:0]  sync;
	} iavc_txctl_t;

	// receive unpack control layout
	typedef struct packed {
		logic [1:0]  unused_hi;
		logic [1:0]  rx_app_clock_select;
		logic [18:0] unused_mid;
		logic        send_now_on_crc_error;
		logic        stamp_check_disable;
		logic        drop_unreliable_packets;
		logic        source_packet_ready;
		logic        rx_enable;
		logic [1:0]  byte_pad_strip;
		logic        stamp_processing_enable;
		logic        rx_reset;
	} iavc_rxctl_t;

	// packet status from the receive datapath
	typedef struct packed {
		logic        start;
		logic        crc_error;
		logic        key;
		logic        stamp_ok;
		logic [31:0] hq1;
		logic [31:0] hq2;
	} iavc_rxpkt_t;

	// delivery decision toward the receive datapath
	typedef enum logic [1:0] {
		IAVC_DLV_WAIT  = 2'b00,
		IAVC_DLV_SEND  = 2'b01,
		IAVC_DLV_DROP  = 2'b10
	} iavc_dlv_t;

endpackage
`default_nettype wire
